// File: design/sbcj_regs.svh
`ifndef SBCJ_REGS_SVH
`define SBCJ_REGS_SVH
// Function
// RULE1: Signed ge branch taken when N equals overflow
// RULE2: Signed lt branch taken when N differs overflow
// RULE3: Signed le taken on zero or N differs
// RULE4: Acc-zero branch on all-clear accumulator, unmodified
// RULE5: Relative branch: PC plus 2, add displacement
// RULE6: Signed ge opcode is 58h plus displacement
// RULE7: Signed lt opcode is 48h plus displacement
// RULE8: Acc-zero branch opcode is 60h plus displacement
// RULE9: Binary mode needs escape for signed branches
// RULE10: Call pushes PC plus three, low first
// RULE11: Stack pointer pre-incremented per byte, ends +2
// RULE12: Direct call target high then low byte
// RULE13: Direct targets keep upper PC bits
// RULE14: Direct call opcode is 12h, high, low
// RULE15: Indirect call shares pushes, ends nibble 0100
// RULE16: Direct jump loads PC from bytes two, three
// RULE17: Direct jump opcode 02h, never escaped
// RULE18: Indirect jump 89h, register, 0100, loads PC
// RULE19: Acc-zero branch and direct call never escaped
// RULE20: No flag modified by this group
`define SBCJ_OP_ESC       8'ha5
`define SBCJ_OP_SGE       8'h58
`define SBCJ_OP_SLT       8'h48
`define SBCJ_OP_SLE       8'h08
`define SBCJ_OP_AZ        8'h60
`define SBCJ_OP_LONG_SUBROUTINE_CALL     8'h12
`define SBCJ_OP_LONG_UNCONDITIONAL_JUMP      8'h02
`define SBCJ_OP_ICALL     8'h99
`define SBCJ_OP_IJMP      8'h89
`define SBCJ_IND_NIB      4'h4
`define SBCJ_REL_LEN      24'h000002
`define SBCJ_CALL_LEN     24'h000003
`define SBCJ_IND_LEN_SRC  24'h000002
`define SBCJ_IND_LEN_BIN  24'h000003
`define SBCJ_PC_RESET     24'hff0000
`define SBCJ_SP_RESET     8'h07
`endif

// File: design/sbcj_pkg.sv
package sbcj_pkg;
  typedef enum logic [6:0] {
    SBCJ_IDLE  = 7'b0000001,
    SBCJ_OPC   = 7'b0000010,
    SBCJ_BYTE1 = 7'b0000100,
    SBCJ_BYTE2 = 7'b0001000,
    SBCJ_PUSHL = 7'b0010000,
    SBCJ_PUSHH = 7'b0100000,
    SBCJ_DONE  = 7'b1000000
  } sbcj_state_t;
  typedef enum logic [3:0] {
    SBCJ_K_NONE, SBCJ_K_SGE, SBCJ_K_SLT, SBCJ_K_SLE, SBCJ_K_AZ,
    SBCJ_K_LONG_SUBROUTINE_CALL, SBCJ_K_LONG_UNCONDITIONAL_JUMP, SBCJ_K_ICALL, SBCJ_K_IJMP
  } sbcj_kind_t;
endpackage

// File: design/sbcj_fetch_if.sv
interface sbcj_fetch_if;
  import sbcj_pkg::*;
  logic       byteValid;
  logic [7:0] byteData;
  logic       byteTake;
  logic       opValid;
  sbcj_kind_t opKind;
  logic       opEscaped;
  logic [3:0] opReg;
  modport decoder (input byteValid, input byteData, output byteTake, output opValid, output opKind,
                   output opEscaped, output opReg);
  modport core (output byteValid, output byteData, input byteTake, input opValid, input opKind,
                input opEscaped, input opReg);
endinterface

// File: design/sbcj_decode.sv
`include "sbcj_regs.svh"
module sbcj_decode (
  input  wire logic               binaryMode,
  sbcj_fetch_if.decoder           fif
);
  import sbcj_pkg::*;
  logic esc;
  logic [7:0] op;
  assign esc = fif.byteValid && fif.byteData == `SBCJ_OP_ESC;
  assign op  = fif.byteData;
  assign fif.byteTake = fif.byteValid;
  assign fif.opEscaped = 1'b0;
  assign fif.opReg = 4'h0;
  // Combinational opcode classification; escState comes from core via opEscaped-less path
  always_comb begin
    fif.opKind  = SBCJ_K_NONE;
    fif.opValid = fif.byteValid && !esc;
    case (op)
      `SBCJ_OP_SGE:   fif.opKind = SBCJ_K_SGE;   // see RULE6
      `SBCJ_OP_SLT:   fif.opKind = SBCJ_K_SLT;   // see RULE7
      `SBCJ_OP_SLE:   fif.opKind = SBCJ_K_SLE;
      `SBCJ_OP_AZ:    fif.opKind = SBCJ_K_AZ;    // see RULE8
      `SBCJ_OP_LONG_SUBROUTINE_CALL: fif.opKind = SBCJ_K_LONG_SUBROUTINE_CALL; // see RULE14
      `SBCJ_OP_LONG_UNCONDITIONAL_JUMP:  fif.opKind = SBCJ_K_LONG_UNCONDITIONAL_JUMP;  // see RULE17
      `SBCJ_OP_ICALL: fif.opKind = SBCJ_K_ICALL;
      `SBCJ_OP_IJMP:  fif.opKind = SBCJ_K_IJMP;
      default:        fif.opKind = SBCJ_K_NONE;
    endcase
  end
endmodule // sbcj_decode

// File: design/sbcj_unit.sv
`include "sbcj_regs.svh"
module sbcj_unit (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        binaryMode,
  input  wire logic        codeValid,
  input  wire logic [7:0]  codeByte,
  output logic             codeTake,
  input  wire logic        negFlag,
  input  wire logic        overflowFlag,
  input  wire logic        zeroFlag,
  input  wire logic [7:0]  accValue,
  output logic [15:0]      wordRegSel,
  input  wire logic [15:0] wordRegValue,
  output logic             stackWrite,
  output logic [7:0]       stackAddr,
  output logic [7:0]       stackData,
  output logic [23:0]      pcValue,
  output logic [7:0]       stackPointer,
  output logic             instrDone,
  output logic             branchTaken,
  output logic             illegalOp
);
  import sbcj_pkg::*;

  sbcj_fetch_if fif ();
  sbcj_decode u_decode (
    .binaryMode (binaryMode),
    .fif        (fif)
  );

  sbcj_state_t state_reg;
  sbcj_kind_t  kind_reg;
  logic        escSeen_reg;
  logic [7:0]  byte1_reg;
  logic [23:0] pc_reg;
  logic [23:0] ret_reg;
  logic [7:0]  sp_reg;
  logic        taken_reg;
  logic        illegal_reg;
  logic        done_reg;
  logic        wr_reg;
  logic [7:0]  waddr_reg;
  logic [7:0]  wdata_reg;
  logic [3:0]  reg_reg;
  logic        wantEsc;
  logic        kindOk;
  logic [23:0] nextPc;

  function automatic logic [23:0] sbcjAdd(input logic [23:0] base, input logic [23:0] inc);
    sbcjAdd = base + inc;
  endfunction

  // Branch condition, flags only read: none are written here (see RULE20)
  function automatic logic sbcjCond(input sbcj_kind_t k, input logic n, input logic v,
                                    input logic z, input logic [7:0] a);
    case (k)
      SBCJ_K_SGE: sbcjCond = (n == v);          // see RULE1
      SBCJ_K_SLT: sbcjCond = (n != v);          // see RULE2
      SBCJ_K_SLE: sbcjCond = z || (n != v);     // see RULE3
      SBCJ_K_AZ:  sbcjCond = (a == 8'h00);      // see RULE4
      default:    sbcjCond = 1'b0;
    endcase
  endfunction

  assign fif.byteValid = codeValid && (state_reg == SBCJ_OPC);
  assign fif.byteData  = codeByte;
  assign nextPc        = sbcjAdd(pc_reg, `SBCJ_CALL_LEN);
  assign codeTake = codeValid && (state_reg == SBCJ_OPC || state_reg == SBCJ_BYTE1 || state_reg == SBCJ_BYTE2);

  // Signed branches and indirect forms need the escape in binary mode only
  always_comb begin
    case (fif.opKind)
      SBCJ_K_SGE, SBCJ_K_SLT, SBCJ_K_SLE, SBCJ_K_ICALL, SBCJ_K_IJMP: wantEsc = binaryMode; // see RULE9
      default: wantEsc = 1'b0;                                        // see RULE17, RULE19
    endcase
    kindOk = (fif.opKind != SBCJ_K_NONE) && (wantEsc == escSeen_reg);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg   <= SBCJ_IDLE;
      kind_reg    <= SBCJ_K_NONE;
      escSeen_reg <= 1'b0;
      byte1_reg   <= 8'h00;
      reg_reg     <= 4'h0;
      illegal_reg <= 1'b0;
    end else begin
      illegal_reg <= 1'b0;
      case (state_reg)
        SBCJ_IDLE: state_reg <= SBCJ_OPC;
        SBCJ_OPC: begin
          if (codeValid) begin
            if (codeByte == `SBCJ_OP_ESC && !escSeen_reg) begin
              escSeen_reg <= 1'b1;
            end else if (kindOk) begin
              kind_reg  <= fif.opKind;
              state_reg <= SBCJ_BYTE1;
            end else begin
              escSeen_reg <= 1'b0;
              illegal_reg <= 1'b1;
            end
          end
        end
        SBCJ_BYTE1: begin
          if (codeValid) begin
            byte1_reg <= codeByte;
            reg_reg   <= codeByte[7:4];
            case (kind_reg)
              SBCJ_K_LONG_SUBROUTINE_CALL, SBCJ_K_LONG_UNCONDITIONAL_JUMP: state_reg <= SBCJ_BYTE2;
              SBCJ_K_ICALL: begin
                if (codeByte[3:0] == `SBCJ_IND_NIB) begin // see RULE15
                  state_reg <= SBCJ_PUSHL;
                end else begin
                  illegal_reg <= 1'b1;
                  state_reg   <= SBCJ_DONE;
                end
              end
              SBCJ_K_IJMP: begin
                illegal_reg <= (codeByte[3:0] != `SBCJ_IND_NIB); // see RULE18
                state_reg   <= SBCJ_DONE;
              end
              default: state_reg <= SBCJ_DONE;
            endcase
          end
        end
        SBCJ_BYTE2: begin
          if (codeValid) begin
            state_reg <= (kind_reg == SBCJ_K_LONG_SUBROUTINE_CALL) ? SBCJ_PUSHL : SBCJ_DONE;
          end
        end
        SBCJ_PUSHL: state_reg <= SBCJ_PUSHH;
        SBCJ_PUSHH: state_reg <= SBCJ_DONE;
        SBCJ_DONE: begin
          escSeen_reg <= 1'b0;
          state_reg   <= SBCJ_OPC;
        end
        default: state_reg <= SBCJ_IDLE;
      endcase
    end
  end

  // Program counter and return address
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pc_reg    <= `SBCJ_PC_RESET;
      ret_reg   <= 24'h000000;
      taken_reg <= 1'b0;
    end else begin
      taken_reg <= 1'b0;
      if (state_reg == SBCJ_BYTE1 && codeValid) begin
        case (kind_reg)
          SBCJ_K_SGE, SBCJ_K_SLT, SBCJ_K_SLE, SBCJ_K_AZ: begin
            // see RULE5
            if (sbcjCond(kind_reg, negFlag, overflowFlag, zeroFlag, accValue)) begin
              pc_reg    <= sbcjAdd(sbcjAdd(pc_reg, `SBCJ_REL_LEN), {{16{codeByte[7]}}, codeByte});
              taken_reg <= 1'b1;
            end else begin
              pc_reg <= sbcjAdd(pc_reg, `SBCJ_REL_LEN);
            end
          end
          SBCJ_K_ICALL: begin
            ret_reg <= sbcjAdd(pc_reg, escSeen_reg ? `SBCJ_IND_LEN_BIN : `SBCJ_CALL_LEN); // see RULE10
          end
          SBCJ_K_IJMP: begin
            // A refused register byte leaves the counter where it was
            if (codeByte[3:0] == `SBCJ_IND_NIB) begin
              pc_reg    <= {pc_reg[23:16], wordRegValue}; // see RULE18
              taken_reg <= 1'b1;
            end
          end
          default: ;
        endcase
      end
      if (state_reg == SBCJ_BYTE2 && codeValid) begin
        ret_reg   <= nextPc; // see RULE10
        // Upper bits from the next instruction address stay put
        pc_reg    <= {nextPc[23:16], byte1_reg, codeByte}; // see RULE12, RULE13, RULE16
        taken_reg <= 1'b1;
      end
      if (state_reg == SBCJ_PUSHH && kind_reg == SBCJ_K_ICALL) begin
        pc_reg    <= {ret_reg[23:16], wordRegValue};
        taken_reg <= 1'b1;
      end
    end
  end

  // Stack pushes: pre-increment, low byte first
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sp_reg    <= `SBCJ_SP_RESET;
      wr_reg    <= 1'b0;
      waddr_reg <= 8'h00;
      wdata_reg <= 8'h00;
    end else begin
      wr_reg <= 1'b0;
      if (state_reg == SBCJ_PUSHL) begin
        sp_reg    <= sp_reg + 8'h01; // see RULE11
        waddr_reg <= sp_reg + 8'h01;
        wdata_reg <= ret_reg[7:0];   // see RULE10
        wr_reg    <= 1'b1;
      end else if (state_reg == SBCJ_PUSHH) begin
        sp_reg    <= sp_reg + 8'h01; // see RULE11
        waddr_reg <= sp_reg + 8'h01;
        wdata_reg <= ret_reg[15:8];
        wr_reg    <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (state_reg == SBCJ_DONE);
    end
  end

  // The indirect jump reads the register in the cycle its field arrives
  assign wordRegSel   = 16'h0001 << ((state_reg == SBCJ_BYTE1) ? codeByte[7:4] : reg_reg);
  assign stackWrite   = wr_reg;
  assign stackAddr    = waddr_reg;
  assign stackData    = wdata_reg;
  assign pcValue      = pc_reg;
  assign stackPointer = sp_reg;
  assign instrDone    = done_reg;
  assign branchTaken  = taken_reg;
  assign illegalOp    = illegal_reg;
endmodule // sbcj_unit

// File: testbench/sbcj_unit_props.sv
module sbcj_unit_props (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        stackWrite,
  input wire logic [7:0]  stackAddr,
  input wire logic [7:0]  stackPointer,
  input wire logic        instrDone,
  input wire logic        branchTaken,
  input wire logic        illegalOp,
  input wire logic [23:0] pcValue
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_push_at_sp: assert property (stackWrite |-> stackAddr == stackPointer) else $error("push off sp");
  a_push_pair: assert property ($rose(stackWrite) |=> stackWrite ##1 !stackWrite) else $error("push count");
  a_push_step: assert property (stackWrite && $past(stackWrite) |-> stackAddr == $past(stackAddr) + 8'h01)
    else $error("push order");
  a_sp_moves_on_push: assert property ($changed(stackPointer) |-> stackWrite) else $error("stray sp");
  // Compared against the pointer seen just before the first push
  a_sp_two_up: assert property ($fell(stackWrite) |-> stackPointer == $past(stackPointer, 3) + 8'h02)
    else $error("sp not plus two");
  a_done_pulse: assert property (instrDone |=> !instrDone) else $error("done held");
  a_taken_done: assert property (branchTaken |-> ##[0:4] instrDone) else $error("no done");
  a_illegal_hold: assert property (illegalOp |-> $stable(pcValue)) else $error("pc moved on refusal");
endmodule // sbcj_unit_props
bind sbcj_unit sbcj_unit_props chk (.mclk(mclk), .rst(rst), .stackWrite(stackWrite), .stackAddr(stackAddr),
  .stackPointer(stackPointer), .instrDone(instrDone), .branchTaken(branchTaken), .illegalOp(illegalOp),
  .pcValue(pcValue));

// File: testbench/sbcj_mem_model.sv
module sbcj_mem_model (
  input  wire logic        mclk,
  input  wire logic        rst,
  output logic             codeValid,
  output logic [7:0]       codeByte,
  input  wire logic        codeTake,
  input  wire logic [15:0] wordRegSel,
  output logic [15:0]      wordRegValue,
  input  wire logic        stackWrite,
  input  wire logic [7:0]  stackAddr,
  input  wire logic [7:0]  stackData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rom [256];
  logic [7:0] stk [256];
  logic [7:0] wrPtr;
  logic [7:0] rdPtr;
  initial foreach (rom[i]) rom[i] = 8'h00;
  assign codeValid = rdPtr != wrPtr;
  // Idle bus shows the inverse of the last byte so a stale byte never passes as fresh
  assign codeByte = codeValid ? rom[rdPtr] : ~rom[rdPtr - 8'h01];
  always_comb begin
    wordRegValue = 16'hdead;
    for (int i = 0; i < 16; i++) if (wordRegSel[i]) wordRegValue = 16'h3000 + 16'(i) * 16'h0111;
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) rdPtr <= 8'h00;
    else if (codeValid && codeTake) rdPtr <= rdPtr + 8'h01;
  end
  always_ff @(posedge mclk) begin
    if (stackWrite) stk[stackAddr] <= stackData;
  end
endmodule // sbcj_mem_model

// File: testbench/signed_branch_call_jump_unit_bench.sv
module signed_branch_call_jump_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic bin, esc; logic [7:0] op, rel; logic n, v, z; logic [7:0] acc; logic tk;} sbcj_row_t;
  localparam sbcj_row_t rows [12] = '{
    '{0, 0, 8'h58, 8'h7f, 0, 0, 0, 8'h01, 1}, '{0, 0, 8'h58, 8'h10, 1, 0, 0, 8'h01, 0},
    '{0, 0, 8'h48, 8'h80, 1, 0, 0, 8'h01, 1}, '{0, 0, 8'h48, 8'h10, 1, 1, 0, 8'h01, 0},
    '{0, 0, 8'h08, 8'hfe, 0, 0, 1, 8'h01, 1}, '{0, 0, 8'h08, 8'h20, 0, 1, 0, 8'h01, 1},
    '{0, 0, 8'h08, 8'h20, 1, 1, 0, 8'h01, 0}, '{0, 0, 8'h60, 8'h04, 1, 0, 1, 8'h00, 1},
    '{0, 0, 8'h60, 8'h04, 0, 0, 1, 8'h80, 0}, '{1, 1, 8'h58, 8'h05, 1, 1, 0, 8'h01, 1},
    '{1, 1, 8'h48, 8'h05, 0, 0, 0, 8'h01, 0}, '{1, 0, 8'h60, 8'hf0, 0, 0, 0, 8'h00, 1}};
  logic             mclk = 1'b0;
  logic             rst, binaryMode, negFlag, overflowFlag, zeroFlag, seenTaken, seenIll;
  logic [7:0]       accValue;
  logic [23:0]      expPc, ret;
  wire logic        codeValid, codeTake, stackWrite, instrDone, branchTaken, illegalOp;
  wire logic [7:0]  codeByte, stackAddr, stackData, stackPointer;
  wire logic [15:0] wordRegSel, wordRegValue;
  wire logic [23:0] pcValue;
  int               numErrors = 0;
  int               checked = 0;
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    if (branchTaken === 1'b1) seenTaken <= 1'b1;
    if (illegalOp === 1'b1) seenIll <= 1'b1;
  end
  sbcj_unit uut (.mclk, .rst, .binaryMode, .codeValid, .codeByte, .codeTake, .negFlag, .overflowFlag, .zeroFlag,
    .accValue, .wordRegSel, .wordRegValue, .stackWrite, .stackAddr, .stackData, .pcValue, .stackPointer,
    .instrDone, .branchTaken, .illegalOp);
  sbcj_mem_model mem (.mclk, .rst, .codeValid, .codeByte, .codeTake, .wordRegSel, .wordRegValue, .stackWrite,
    .stackAddr, .stackData);
  task automatic endSim();
    $display("checked %0d errors %0d", checked, numErrors);
    if (numErrors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      numErrors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic feed(input logic [7:0] b [$]);
    foreach (b[i]) begin
      mem.rom[mem.wrPtr] = b[i];
      mem.wrPtr = mem.wrPtr + 8'h01;
    end
  endtask
  task automatic runOp();
    int i;
    seenTaken = 1'b0;
    seenIll = 1'b0;
    for (i = 0; i < 40; i++) begin
      @(negedge mclk);
      if (illegalOp === 1'b1) seenIll = 1'b1;
      if (instrDone === 1'b1 || illegalOp === 1'b1) break;
    end
    if (i == 40) begin
      numErrors++;
      $display("wrong value at %0t: no completion", $time);
      endSim();
    end
  endtask
  task automatic pushChk(input logic [7:0] top);
    chk({16'h0000, stackPointer}, {16'h0000, top});
    chk({8'h00, mem.stk[top], mem.stk[top - 8'h01]}, {8'h00, ret[15:0]});
  endtask
  initial begin
    rst = 1'b1;
    binaryMode = 1'b0;
    negFlag = 1'b0;
    overflowFlag = 1'b0;
    zeroFlag = 1'b0;
    accValue = 8'h00;
    mem.wrPtr = 8'h00;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    expPc = 24'hff0000;
    chk(pcValue, expPc);
    chk({16'h0000, stackPointer}, 24'h000007);
    @(negedge mclk);
    foreach (rows[k]) begin
      binaryMode = rows[k].bin;
      negFlag = rows[k].n;
      overflowFlag = rows[k].v;
      zeroFlag = rows[k].z;
      accValue = rows[k].acc;
      if (rows[k].esc) feed('{8'ha5, rows[k].op, rows[k].rel});
      else feed('{rows[k].op, rows[k].rel});
      runOp();
      expPc = expPc + 24'h000002 + (rows[k].tk ? {{16{rows[k].rel[7]}}, rows[k].rel} : 24'h000000);
      chk(pcValue, expPc);
      chk({23'h0, seenTaken}, {23'h0, rows[k].tk});
    end
    binaryMode = 1'b0;
    ret = expPc + 24'h000003;
    feed('{8'h12, 8'h12, 8'h34});
    runOp();
    expPc = {expPc[23:16], 16'h1234};
    chk(pcValue, expPc);
    pushChk(8'h09);
    ret = expPc + 24'h000003;
    feed('{8'h99, 8'h24});
    runOp();
    expPc = {expPc[23:16], 16'h3222};
    chk(pcValue, expPc);
    pushChk(8'h0b);
    binaryMode = 1'b1;
    feed('{8'h02, 8'hab, 8'hcd});
    runOp();
    expPc = {expPc[23:16], 16'habcd};
    chk(pcValue, expPc);
    feed('{8'ha5, 8'h89, 8'h14});
    runOp();
    expPc = {expPc[23:16], 16'h3111};
    chk(pcValue, expPc);
    feed('{8'h58});
    runOp();
    chk({23'h0, seenIll}, 24'h000001);
    feed('{8'ha5, 8'h02});
    runOp();
    chk({23'h0, seenIll}, 24'h000001);
    chk(pcValue, expPc);
    // Reset lands in mid-call, after the opcode byte only
    feed('{8'h12});
    @(negedge mclk);
    rst = 1'b1;
    mem.wrPtr = 8'h00;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    chk(pcValue, 24'hff0000);
    chk({16'h0000, stackPointer}, 24'h000007);
    endSim();
  end
endmodule // signed_branch_call_jump_unit_bench
